//--- design/mrc_delay_line.sv
/*
 * mrc_delay_line: holds a posted read or write for the programmed
 * additive-latency cycles, then issues it internally.
 * assumes: same clock as the top; delay of zero passes straight through.
 */
`timescale 1ns/1ns
module mrc_delay_line
   import mrc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // posted command in
   input wire logic cmd_in,
   input wire logic cmd_is_write,
   input wire logic [CNT_W-1:0] delay,
   // internal command out
   output logic cmd_out,
   output logic cmd_out_write
);
   localparam int DEPTH = 16;
   logic [DEPTH-1:0] v_reg;
   logic [DEPTH-1:0] v_next;
   logic [DEPTH-1:0] w_reg;
   logic [DEPTH-1:0] w_next;

   // shift line; the command enters at the tap picked by the delay
   always_comb begin
      v_next = {1'b0, v_reg[DEPTH-1:1]};
      w_next = {1'b0, w_reg[DEPTH-1:1]};
      if (cmd_in && delay != 4'h0) begin
         v_next[delay - 4'h1] = 1'b1;
         w_next[delay - 4'h1] = cmd_is_write;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         v_reg <= '0;
         w_reg <= '0;
      end else begin
         v_reg <= v_next;
         w_reg <= w_next;
      end
   end

   // zero additive delay bypasses the line
   assign cmd_out = (cmd_in && delay == 4'h0) | v_reg[0];
   assign cmd_out_write = (cmd_in && delay == 4'h0) ? cmd_is_write : w_reg[0];
endmodule : mrc_delay_line

//--- design/mrc_mode_regs.sv
/*
 * mrc_mode_regs: mode-register set decode and configuration state.
 * assumes: command pins are registered from the board through three flops;
 * the controller observes all timing waits itself.
 */
`timescale 1ns/1ns
module mrc_mode_regs
   import mrc_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESET,
   // command pins
   input wire logic CS_N,
   input wire logic RAS_N,
   input wire logic CAS_N,
   input wire logic WE_N,
   input wire logic [2:0] BA,
   input wire logic [ADDR_W-1:0] ADDR,
   // power state indications
   input wire logic SELF_REFRESH,
   input wire logic PRECHARGE_PD,
   input wire logic WRITE_ACTIVE,
   input wire logic ODT_PIN,
   // dll and termination
   output logic DLL_RUN,
   output logic EXIT_SLOW,
   output logic [1:0] DRIVE_IMPEDANCE,
   output logic [2:0] TERM_NOMINAL,
   output logic [1:0] TERM_WRITE,
   output logic TERM_WRITE_ACTIVE,
   output logic OUT_DISABLE,
   output logic WRITE_LEVELING,
   // latencies
   output logic [CNT_W-1:0] READ_TOTAL_DELAY,
   output logic [CNT_W-1:0] WRITE_TOTAL_DELAY,
   output logic INT_CMD,
   output logic INT_CMD_WRITE,
   // refresh
   output logic [1:0] REFRESH_RATE,
   output logic [7:0] BANK_REFRESH_MASK,
   output logic CONFIG_ERROR
);
   localparam int NPIN = 7 + ADDR_W;
   localparam int NSTAT = 4;
   logic [NPIN-1:0] s1_reg;
   logic [NPIN-1:0] s2_reg;
   logic [NPIN-1:0] s3_reg;
   logic [NSTAT-1:0] t1_reg;
   logic [NSTAT-1:0] t2_reg;
   logic [NSTAT-1:0] t3_reg;
   logic [NSTAT-1:0] st_reg;
   logic [NSTAT-1:0] st_next;
   logic [NPIN-1:0] cmd_reg;
   logic [NPIN-1:0] cmd_next;
   logic [NPIN-1:0] last_reg;
   logic [NPIN-1:0] last_next;
   logic [ADDR_W-1:0] base_mode_reg;
   logic [ADDR_W-1:0] base_mode_next;
   logic [ADDR_W-1:0] dll_drive_termination_cfg_reg;
   logic [ADDR_W-1:0] dll_drive_termination_cfg_next;
   logic [ADDR_W-1:0] write_latency_refresh_cfg_reg;
   logic [ADDR_W-1:0] write_latency_refresh_cfg_next;
   mrc_cmd_type cmd_kind;
   logic [CNT_W-1:0] additive_delay;
   logic [CNT_W-1:0] read_cas_delay;
   logic [CNT_W-1:0] write_cas_delay;
   logic self_refresh_extended_range;
   logic [2:0] partial_array_refresh_select;
   logic post_out;
   logic post_out_write;
   logic dll_run_next;
   logic exit_slow_next;
   logic twa_next;
   logic [7:0] bank_mask_next;
   logic cfg_err_next;
   logic [CNT_W-1:0] rtd_next;
   logic [CNT_W-1:0] wtd_next;

   // three-flop pin sampling; a change counts once stages two and three agree
   // the all-ones reset image decodes as a deselect, never as a command
   always_ff @(posedge CLK) begin
      if (RESET) begin
         s1_reg <= {NPIN{1'b1}};
         s2_reg <= {NPIN{1'b1}};
         s3_reg <= {NPIN{1'b1}};
         t1_reg <= '0;
         t2_reg <= '0;
         t3_reg <= '0;
      end else begin
         s1_reg <= {CS_N, RAS_N, CAS_N, WE_N, BA, ADDR};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         t1_reg <= {SELF_REFRESH, PRECHARGE_PD, WRITE_ACTIVE, ODT_PIN};
         t2_reg <= t1_reg;
         t3_reg <= t2_reg;
      end
   end

   // accept a new pin image only when stable; an image held for many cycles
   // is taken once, so a long hold never repeats a posted read or write
   always_comb begin
      cmd_next = {NPIN{1'b1}};
      last_next = last_reg;
      st_next = st_reg;
      if (s2_reg == s3_reg && s3_reg != last_reg) begin
         cmd_next = s3_reg;
         last_next = s3_reg;
      end
      if (t2_reg == t3_reg) begin
         st_next = t3_reg;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         cmd_reg <= {NPIN{1'b1}};
         last_reg <= {NPIN{1'b1}};
         st_reg <= '0;
      end else begin
         cmd_reg <= cmd_next;
         last_reg <= last_next;
         st_reg <= st_next;
      end
   end

   // command classification from the sampled control pins
   // only the four control pins matter here; the address is read later
   always_comb begin
      if (cmd_reg[NPIN-1]) begin
         cmd_kind = CMD_NONE;
      end else if (cmd_reg[NPIN-2:NPIN-4] == 3'h0) begin
         cmd_kind = CMD_MRS;
      end else if (cmd_reg[NPIN-2:NPIN-3] == 2'h2) begin
         cmd_kind = CMD_RDWR;
      end else begin
         cmd_kind = CMD_OTHER;
      end
   end

   // register loads, selected by the bank-address pins
   // a select of three, or one with bank bit two set, is dropped without trace
   always_comb begin
      base_mode_next = base_mode_reg;
      dll_drive_termination_cfg_next = dll_drive_termination_cfg_reg;
      write_latency_refresh_cfg_next = write_latency_refresh_cfg_reg;
      if (cmd_kind == CMD_MRS) begin
         if (cmd_reg[ADDR_W+2:ADDR_W] == SEL_BASE) begin
            base_mode_next = cmd_reg[ADDR_W-1:0];
         end else if (cmd_reg[ADDR_W+2:ADDR_W] == SEL_DLL_DRV) begin
            dll_drive_termination_cfg_next = cmd_reg[ADDR_W-1:0];
         end else if (cmd_reg[ADDR_W+2:ADDR_W] == SEL_WR_LAT) begin
            write_latency_refresh_cfg_next = cmd_reg[ADDR_W-1:0];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         base_mode_reg <= RST_BASE;
         dll_drive_termination_cfg_reg <= RST_DLL_DRV;
         write_latency_refresh_cfg_reg <= RST_WR_LAT;
      end else begin
         base_mode_reg <= base_mode_next;
         dll_drive_termination_cfg_reg <= dll_drive_termination_cfg_next;
         write_latency_refresh_cfg_reg <= write_latency_refresh_cfg_next;
      end
   end

   // field extraction and latency arithmetic
   // sums stay four bits wide; settings past the supported bins wrap around
   always_comb begin
      additive_delay = 4'h0;
      read_cas_delay = CL_BASE + {1'b0, base_mode_reg[B_CAS_HI:B_CAS_LO]}
         + {3'h0, base_mode_reg[B_CAS_EXT]};
      write_cas_delay = CWL_BASE
         + {1'b0, write_latency_refresh_cfg_reg[S_CWL_HI:S_CWL_LO]};
      // additive delay 0, CL-1 or CL-2; the reserved code reads as zero
      case (dll_drive_termination_cfg_reg[F_AL_HI:F_AL_LO])
         2'h1: additive_delay = read_cas_delay - 4'h1;
         2'h2: additive_delay = read_cas_delay - 4'h2;
         default: additive_delay = 4'h0;
      endcase
      self_refresh_extended_range = write_latency_refresh_cfg_reg[S_SRT];
      partial_array_refresh_select = write_latency_refresh_cfg_reg[S_PARTIAL_ARRAY_REFRESH_SELECT_HI:S_PARTIAL_ARRAY_REFRESH_SELECT_LO];
      rtd_next = additive_delay + read_cas_delay;
      wtd_next = additive_delay + write_cas_delay;
   end

   // dll state: off when disabled, during self-refresh, or frozen on slow exit
   // status pins pass the same filter, so the dll follows them a few cycles late
   always_comb begin
      exit_slow_next = ~base_mode_reg[B_PD_FAST];
      dll_run_next = ~dll_drive_termination_cfg_reg[F_DLL_OFF]
         && !st_reg[3]
         && !(st_reg[2] && !base_mode_reg[B_PD_FAST]);
   end

   // write termination: applies during writes regardless of nominal value,
   // but never while leveling; dll is needed only for this path
   always_comb begin
      twa_next = st_reg[1] && st_reg[0]
         && write_latency_refresh_cfg_reg[S_RWR_HI:S_RWR_LO] != RWR_OFF
         && !dll_drive_termination_cfg_reg[F_WLEV]
         && dll_run_next;
      cfg_err_next = (write_latency_refresh_cfg_reg[S_RWR_HI:S_RWR_LO] == 2'h3)
         || write_latency_refresh_cfg_reg[S_CWL_HI];
   end

   // refreshed bank mask; banks outside it may lose data in self-refresh
   always_comb begin
      case (partial_array_refresh_select)
         3'h0: bank_mask_next = 8'hff;
         3'h1: bank_mask_next = 8'h0f;
         3'h2: bank_mask_next = 8'h03;
         3'h3: bank_mask_next = 8'h01;
         3'h4: bank_mask_next = 8'hfc;
         3'h5: bank_mask_next = 8'hf0;
         3'h6: bank_mask_next = 8'hc0;
         default: bank_mask_next = 8'h80;
      endcase
   end

   // posted read/write held for the additive delay
   // a zero additive delay passes the command on in its decode cycle;
   // the write flag follows the write-enable pin of the same image
   mrc_delay_line u_post (
      .clk(CLK),
      .reset(RESET),
      .cmd_in(cmd_kind == CMD_RDWR),
      .cmd_is_write(~cmd_reg[NPIN-4]),
      .delay(additive_delay),
      .cmd_out(post_out),
      .cmd_out_write(post_out_write)
   );

   // registered outputs
   // every output is a flop; derived values trail the register load by one
   always_ff @(posedge CLK) begin
      if (RESET) begin
         DLL_RUN <= 1'b0;
         EXIT_SLOW <= 1'b1;
         DRIVE_IMPEDANCE <= 2'h0;
         TERM_NOMINAL <= 3'h0;
         TERM_WRITE <= 2'h0;
         TERM_WRITE_ACTIVE <= 1'b0;
         OUT_DISABLE <= 1'b0;
         WRITE_LEVELING <= 1'b0;
         // latencies of the all-zero registers, so no cycle shows a zero delay
         READ_TOTAL_DELAY <= CL_BASE;
         WRITE_TOTAL_DELAY <= CWL_BASE;
         INT_CMD <= 1'b0;
         INT_CMD_WRITE <= 1'b0;
         REFRESH_RATE <= REF_1X;
         BANK_REFRESH_MASK <= 8'hff;
         CONFIG_ERROR <= 1'b0;
      end else begin
         DLL_RUN <= dll_run_next;
         EXIT_SLOW <= exit_slow_next;
         DRIVE_IMPEDANCE <= {dll_drive_termination_cfg_reg[F_DRV_HI],
            dll_drive_termination_cfg_reg[F_DRV_LO]};
         TERM_NOMINAL <= {dll_drive_termination_cfg_reg[F_NOM_2],
            dll_drive_termination_cfg_reg[F_NOM_1], dll_drive_termination_cfg_reg[F_NOM_0]};
         TERM_WRITE <= write_latency_refresh_cfg_reg[S_RWR_HI:S_RWR_LO];
         TERM_WRITE_ACTIVE <= twa_next;
         OUT_DISABLE <= dll_drive_termination_cfg_reg[F_QOFF];
         WRITE_LEVELING <= dll_drive_termination_cfg_reg[F_WLEV];
         READ_TOTAL_DELAY <= rtd_next;
         WRITE_TOTAL_DELAY <= wtd_next;
         INT_CMD <= post_out;
         INT_CMD_WRITE <= post_out_write;
         REFRESH_RATE <= self_refresh_extended_range ? REF_2X : REF_1X;
         BANK_REFRESH_MASK <= bank_mask_next;
         CONFIG_ERROR <= cfg_err_next;
      end
   end
endmodule : mrc_mode_regs

//--- design/mrc_pkg.sv
/*
 * mrc_pkg: command codes, mode-register field positions, reset values and
 * decode constants for the DRAM mode-register configuration block.
 * assumes: pins sampled on the rising edge of CLK, one 14-bit address bus.
 */
package mrc_pkg;
   localparam int ADDR_W = 14;
   localparam int CNT_W = 4;
   // bank-address selects of the mode registers
   localparam logic [2:0] SEL_BASE = 3'h0;
   localparam logic [2:0] SEL_DLL_DRV = 3'h1;
   localparam logic [2:0] SEL_WR_LAT = 3'h2;
   // base mode register fields
   localparam int B_PD_FAST = 12;
   localparam int B_CAS_HI = 6;
   localparam int B_CAS_MID = 5;
   localparam int B_CAS_LO = 4;
   localparam int B_CAS_EXT = 2;
   // first extended register fields
   localparam int F_DLL_OFF = 0;
   localparam int F_DRV_LO = 1;
   localparam int F_DRV_HI = 5;
   localparam int F_NOM_0 = 2;
   localparam int F_NOM_1 = 6;
   localparam int F_NOM_2 = 9;
   localparam int F_AL_LO = 3;
   localparam int F_AL_HI = 4;
   localparam int F_WLEV = 7;
   localparam int F_QOFF = 12;
   // second extended register fields
   localparam int S_PARTIAL_ARRAY_REFRESH_SELECT_LO = 0;
   localparam int S_PARTIAL_ARRAY_REFRESH_SELECT_HI = 2;
   localparam int S_CWL_LO = 3;
   localparam int S_CWL_HI = 5;
   localparam int S_SRT = 7;
   localparam int S_RWR_LO = 9;
   localparam int S_RWR_HI = 10;
   // values after reset
   localparam logic [ADDR_W-1:0] RST_BASE = 14'h0000;
   localparam logic [ADDR_W-1:0] RST_DLL_DRV = 14'h0000;
   localparam logic [ADDR_W-1:0] RST_WR_LAT = 14'h0000;
   // latency constants
   localparam logic [CNT_W-1:0] CWL_BASE = 4'h5;
   localparam logic [CNT_W-1:0] CL_BASE = 4'h4;
   // write termination codes
   localparam logic [1:0] RWR_OFF = 2'h0;
   localparam logic [1:0] RWR_RZQ4 = 2'h1;
   localparam logic [1:0] RWR_RZQ2 = 2'h2;
   // refresh rate multipliers
   localparam logic [1:0] REF_1X = 2'h1;
   localparam logic [1:0] REF_2X = 2'h2;
   typedef enum logic [1:0] {CMD_NONE, CMD_MRS, CMD_RDWR, CMD_OTHER} mrc_cmd_type;
endpackage : mrc_pkg

//--- verif/dram_mode_register_config_tb.sv
/* dram_mode_register_config_tb: directed scenarios for mrc_mode_regs.
   assumes: mrc_ctrl_model drives the command pins; checker bound by its file. */
`timescale 1ns/1ns
module dram_mode_register_config_tb
   import mrc_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic req = 1'b0;
   logic is_mrs = 1'b0;
   logic is_wr = 1'b0;
   logic [2:0] ba_i = 3'h0;
   logic [ADDR_W-1:0] addr_i = 14'h0000;
   logic sr = 1'b0;
   logic pd = 1'b0;
   logic wr_act = 1'b0;
   logic odt = 1'b0;
   logic cs_n, ras_n, cas_n, we_n, busy, w_seen;
   logic [2:0] ba, tnom;
   logic [ADDR_W-1:0] addr;
   logic dll_run, exit_slow, twa, out_dis, wlev, int_cmd, int_wr, cfg_err;
   logic [1:0] drv, twr, rate;
   logic [CNT_W-1:0] rtd, wtd;
   logic [7:0] mask;
   logic [7:0] mask_tab [8] = '{8'hff, 8'h0f, 8'h03, 8'h01, 8'hfc, 8'hf0, 8'hc0, 8'h80};
   int fail_count = 0;
   int n_checks = 0;
   int n0, n1, nd;
   always #10 clk = ~clk;
   mrc_ctrl_model u_ctrl (.clk(clk), .req(req), .is_mrs(is_mrs), .is_wr(is_wr), .ba_in(ba_i),
      .addr_in(addr_i), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
      .addr(addr), .busy(busy));
   mrc_mode_regs DUT (.CLK(clk), .RESET(reset), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n),
      .WE_N(we_n), .BA(ba), .ADDR(addr), .SELF_REFRESH(sr), .PRECHARGE_PD(pd),
      .WRITE_ACTIVE(wr_act), .ODT_PIN(odt), .DLL_RUN(dll_run), .EXIT_SLOW(exit_slow),
      .DRIVE_IMPEDANCE(drv), .TERM_NOMINAL(tnom), .TERM_WRITE(twr), .TERM_WRITE_ACTIVE(twa),
      .OUT_DISABLE(out_dis), .WRITE_LEVELING(wlev), .READ_TOTAL_DELAY(rtd),
      .WRITE_TOTAL_DELAY(wtd), .INT_CMD(int_cmd), .INT_CMD_WRITE(int_wr),
      .REFRESH_RATE(rate), .BANK_REFRESH_MASK(mask), .CONFIG_ERROR(cfg_err));
   task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task summarize;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize
   task settle(input int k);
      repeat (k) @(negedge clk);
   endtask : settle
   // one command; n is the cycle of the first internal command, zero if none
   task send(input logic m, input logic w, input logic [2:0] b, input logic [13:0] a,
      output int n);
      n = 0;
      @(negedge clk);
      is_mrs <= m;
      is_wr <= w;
      ba_i <= b;
      addr_i <= a;
      req <= 1'b1;
      @(negedge clk);
      req <= 1'b0;
      for (int i = 1; i < 40; i++) begin
         @(negedge clk);
         if (int_cmd === 1'b1 && n == 0) begin
            n = i;
            w_seen = int_wr;
         end
         if (busy === 1'b0 && i > 11 && (m || n != 0)) break;
      end
   endtask : send
   task mrs(input logic [2:0] b, input logic [13:0] a);
      send(1'b1, 1'b0, b, a, nd);
   endtask : mrs
   task t_reset;
      chk("exit_slow", 16'h1, exit_slow);
      chk("rate", REF_1X, rate);
      chk("mask", 16'h00ff, mask);
      chk("dll_run", 16'h1, dll_run);
   endtask : t_reset
   task t_mr1;
      mrs(SEL_DLL_DRV, 14'h1224);
      chk("drive", 16'h2, drv);
      chk("term_nom", 16'h5, tnom);
      chk("out_dis", 16'h1, out_dis);
      mrs(SEL_DLL_DRV, 14'h0000);
      chk("out_dis", 16'h0, out_dis);
   endtask : t_mr1
   task t_mr2;
      logic [2:0] c;
      for (int k = 0; k < 8; k++) begin
         c = k[2:0];
         mrs(SEL_WR_LAT, {3'h0, c[1:0], 1'b0, c[0], 1'b0, c, c});
         chk("mask", mask_tab[k], mask);
         chk("term_wr", c[1:0], twr);
         chk("rate", c[0] ? REF_2X : REF_1X, rate);
         chk("cfg_err", c[2] | (c[1:0] == 2'h3), cfg_err);
         if (c[2] == 1'b0) chk("wr_delay", CWL_BASE + c, wtd);
      end
      mrs(3'h3, 14'h0000);
      mrs(3'h6, 14'h0000);
      chk("term_wr", 16'h3, twr);
      chk("mask", 16'h0080, mask);
   endtask : t_mr2
   task t_dll;
      sr = 1'b1;
      settle(10);
      chk("dll_run", 16'h0, dll_run);
      sr = 1'b0;
      settle(10);
      chk("dll_run", 16'h1, dll_run);
      pd = 1'b1;
      settle(10);
      chk("dll_run", 16'h0, dll_run);
      mrs(SEL_BASE, 14'h1000);
      settle(20);
      chk("exit_slow", 16'h0, exit_slow);
      chk("dll_run", 16'h1, dll_run);
      pd = 1'b0;
   endtask : t_dll
   task t_twa;
      mrs(SEL_WR_LAT, 14'h0200); // writes run with nominal off
      wr_act = 1'b1;
      odt = 1'b1;
      settle(10);
      chk("twa", 16'h1, twa);
      mrs(SEL_DLL_DRV, 14'h0080); // leveling with nominal off
      chk("twa", 16'h0, twa);
      chk("wlev", 16'h1, wlev);
      mrs(SEL_DLL_DRV, 14'h0001);
      chk("dll_run", 16'h0, dll_run);
      chk("twa", 16'h0, twa);
      mrs(SEL_WR_LAT, 14'h0000);
      mrs(SEL_DLL_DRV, 14'h0000);
      chk("dll_run", 16'h1, dll_run);
      wr_act = 1'b0;
      odt = 1'b0;
   endtask : t_twa
   task t_al;
      settle(16); // let the dll settle before the first read
      chk("rd_delay", CL_BASE, rtd);
      send(1'b0, 1'b0, 3'h0, 14'h0000, n0);
      chk("int_wr", 16'h0, w_seen);
      mrs(SEL_DLL_DRV, 14'h0008);
      chk("rd_delay", 2 * CL_BASE - 1, rtd);
      chk("wr_delay", CL_BASE - 1 + CWL_BASE, wtd);
      send(1'b0, 1'b1, 3'h0, 14'h0000, n1);
      chk("int_wr", 16'h1, w_seen);
      chk("al_gap", CL_BASE - 1, n1 - n0);
      mrs(SEL_BASE, 14'h1014);
      mrs(SEL_DLL_DRV, 14'h0010);
      chk("rd_delay", 2 * (CL_BASE + 2) - 2, rtd);
      chk("wr_delay", CL_BASE + CWL_BASE, wtd);
   endtask : t_al
   // main sequence: reset for three cycles, then each scenario in turn
   initial begin
      settle(3);
      reset = 1'b0;
      settle(2);
      t_reset;
      t_mr1;
      t_mr2;
      t_dll;
      t_twa;
      t_al;
      summarize;
   end
   // watchdog: the scenarios need well under a thousand cycles
   initial begin
      #200000;
      fail_count++;
      summarize;
   end
endmodule : dram_mode_register_config_tb

//--- verif/mrc_ctrl_model.sv
/* mrc_ctrl_model: memory controller issuing mode-set and read/write images.
   assumes: the bench pulses req for one cycle and waits while busy. */
`timescale 1ns/1ns
module mrc_ctrl_model
   import mrc_pkg::*;
(
   // request from the bench
   input wire logic clk,
   input wire logic req,
   input wire logic is_mrs,
   input wire logic is_wr,
   input wire logic [2:0] ba_in,
   input wire logic [ADDR_W-1:0] addr_in,
   // command pins toward the device
   output logic cs_n = 1'b1,
   output logic ras_n = 1'b1,
   output logic cas_n = 1'b1,
   output logic we_n = 1'b1,
   output logic [2:0] ba = 3'h0,
   output logic [ADDR_W-1:0] addr = 14'h0000,
   output logic busy = 1'b0
);
   logic [2:0] cnt = 3'h0;
   // image held three cycles, then idle three; idle address shows the inverse
   always @(negedge clk) begin
      if (!busy && req) begin
         cs_n <= 1'b0;
         ras_n <= !is_mrs;
         cas_n <= 1'b0;
         we_n <= is_mrs ? 1'b0 : !is_wr;
         ba <= ba_in;
         addr <= addr_in;
         busy <= 1'b1;
         cnt <= 3'h5;
      end else if (busy) begin
         cnt <= cnt - 3'h1;
         busy <= (cnt != 3'h0);
         if (cnt == 3'h3) begin
            cs_n <= 1'b1;
            ras_n <= 1'b1;
            cas_n <= 1'b1;
            we_n <= 1'b1;
            ba <= ~ba;
            addr <= ~addr;
         end
      end
   end
endmodule : mrc_ctrl_model

//--- verif/mrc_mode_regs_checker.sv
/* mrc_mode_regs_checker: port-level assertions and covers for mrc_mode_regs.
   assumes: one clock, sync active-high reset, bound by the bind at the foot. */
`timescale 1ns/1ns
module mrc_mode_regs_checker
   import mrc_pkg::*;
(
   // clock, reset and command pins
   input wire logic CLK,
   input wire logic RESET,
   input wire logic CS_N,
   input wire logic RAS_N,
   input wire logic CAS_N,
   input wire logic WE_N,
   input wire logic SELF_REFRESH,
   input wire logic PRECHARGE_PD,
   // watched outputs
   input logic DLL_RUN,
   input logic EXIT_SLOW,
   input logic [2:0] TERM_NOMINAL,
   input logic [1:0] TERM_WRITE,
   input logic TERM_WRITE_ACTIVE,
   input logic OUT_DISABLE,
   input logic WRITE_LEVELING,
   input logic [CNT_W-1:0] WRITE_TOTAL_DELAY,
   input logic INT_CMD,
   input logic [1:0] REFRESH_RATE,
   input logic [7:0] BANK_REFRESH_MASK,
   input logic CONFIG_ERROR
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   logic [4:0] mrs_age_reg;
   logic [4:0] mrs_age_next;
   logic [4:0] rw_age_reg;
   logic [4:0] rw_age_next;
   // ages of the last mode-set and read/write images; reset counts as a mode-set, not as a read/write
   always_comb begin
      mrs_age_next = (mrs_age_reg == 5'h1f) ? mrs_age_reg : mrs_age_reg + 5'h1;
      rw_age_next = (rw_age_reg == 5'h1f) ? rw_age_reg : rw_age_reg + 5'h1;
      if (!CS_N && !RAS_N && !CAS_N && !WE_N) mrs_age_next = 5'h0;
      if (!CS_N && RAS_N && !CAS_N) rw_age_next = 5'h0;
      if (RESET) mrs_age_next = 5'h0;
      if (RESET) rw_age_next = 5'h1f;
   end
   // registers only
   always_ff @(posedge CLK) begin
      mrs_age_reg <= mrs_age_next;
      rw_age_reg <= rw_age_next;
   end
   AST_STAND: assert property (mrs_age_reg > 5'h0c |-> $stable({TERM_NOMINAL, TERM_WRITE,
      OUT_DISABLE, WRITE_LEVELING, EXIT_SLOW, BANK_REFRESH_MASK}))
      else $error("config output moved without a mode-set command");
   AST_INT_CAUSE: assert property (INT_CMD |-> rw_age_reg < 5'h18)
      else $error("internal command without a posted read or write");
   AST_INT_PULSE: assert property (INT_CMD |=> !INT_CMD)
      else $error("internal command longer than one cycle");
   AST_SR_DLL: assert property (SELF_REFRESH [*8] |-> !DLL_RUN && !TERM_WRITE_ACTIVE)
      else $error("dll or write termination on in self-refresh");
   AST_PD_SLOW: assert property ((PRECHARGE_PD && EXIT_SLOW) [*8] |-> !DLL_RUN)
      else $error("dll not frozen in slow-exit power-down");
   AST_PD_FAST: assert property ((PRECHARGE_PD && !EXIT_SLOW && !SELF_REFRESH
      && mrs_age_reg > 5'h0c) [*8] ##0 $past(DLL_RUN) |-> DLL_RUN)
      else $error("dll stopped in fast-exit power-down");
   AST_TWA_CODE: assert property (mrs_age_reg > 5'h0c && TERM_WRITE_ACTIVE
      |-> TERM_WRITE != RWR_OFF && !WRITE_LEVELING)
      else $error("write termination active while off or leveling");
   AST_RST: assert property ($fell(RESET) |-> EXIT_SLOW && REFRESH_RATE == REF_1X
      && BANK_REFRESH_MASK == 8'hff && !OUT_DISABLE)
      else $error("wrong values after reset");
   AST_RATE: assert property (REFRESH_RATE == REF_1X || REFRESH_RATE == REF_2X)
      else $error("refresh rate outside one or two times");
   AST_WL: assert property (WRITE_TOTAL_DELAY >= CWL_BASE)
      else $error("write delay below the shortest write cas delay");
   COV_INT: cover property (INT_CMD);
   COV_TWA: cover property (TERM_WRITE_ACTIVE);
   COV_ERR: cover property (CONFIG_ERROR);
endmodule : mrc_mode_regs_checker
bind mrc_mode_regs mrc_mode_regs_checker u_chk (.CLK(CLK), .RESET(RESET), .CS_N(CS_N),
   .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .SELF_REFRESH(SELF_REFRESH),
   .PRECHARGE_PD(PRECHARGE_PD), .DLL_RUN(DLL_RUN), .EXIT_SLOW(EXIT_SLOW),
   .TERM_NOMINAL(TERM_NOMINAL), .TERM_WRITE(TERM_WRITE), .TERM_WRITE_ACTIVE(TERM_WRITE_ACTIVE),
   .OUT_DISABLE(OUT_DISABLE), .WRITE_LEVELING(WRITE_LEVELING),
   .WRITE_TOTAL_DELAY(WRITE_TOTAL_DELAY), .INT_CMD(INT_CMD), .REFRESH_RATE(REFRESH_RATE),
   .BANK_REFRESH_MASK(BANK_REFRESH_MASK), .CONFIG_ERROR(CONFIG_ERROR));
